// [pkg/wdt_timer_defs.vh]
`ifndef WDT_TIMER_DEFS_VH
`define WDT_TIMER_DEFS_VH

// ***************************************************************
// register offsets
// ***************************************************************
`define ADDR_FLAG_STATUS 8'h01
`define ADDR_TIMER_CONTROL 8'h10
`define ADDR_TIMER_COUNT_VALUE 8'h11

// ***************************************************************
// timer_control fields and reset value
// ***************************************************************
`define MODE_HI 7
`define MODE_LO 6
`define PULSE_SEL_BIT 5
`define TICK_SEL_HI 1
`define TICK_SEL_LO 0
`define TIMER_CONTROL_RESET 8'h03
`define TIMER_CONTROL_WMASK 8'he3
`define COUNT_RESET 8'h00

// ***************************************************************
// timer modes and tick selections
// ***************************************************************
`define MODE_OFF 2'h0
`define MODE_COUNTDOWN 2'h1
`define MODE_WDOG_IRQ 2'h2
`define MODE_WDOG_RST 2'h3
`define TICK_4096HZ 2'h0
`define TICK_64HZ 2'h1
`define TICK_1HZ 2'h2
`define TICK_60S 2'h3

// ***************************************************************
// flag_status fields
// ***************************************************************
`define MINSEC_BIT 7
`define WDOG_BIT 6
`define STAMP_LOW_BIT 5
`define ALARM_BIT 4
`define COUNTDOWN_BIT 3
`define FLAG_STATUS_RESET 8'h00

// ***************************************************************
// oscillator divider taps and timing
// ***************************************************************
`define DIV_WIDTH 15
`define TAP_4096HZ 3
`define TAP_64HZ 9
`define TAP_1HZ 15
`define SECONDS_PER_MINUTE 6'h3c
`define CLK_PERIOD_NS 50
`define RESET_PULSE_FAST_NS 244000
`define RESET_PULSE_SLOW_NS 15625000
`define RESET_PULSE_FAST_CYC 19'h01310
`define RESET_PULSE_SLOW_CYC 19'h4c4b4
`define HALF_SECOND_TICKS 6'h20
`define HALF_MINUTE 6'h1e
`define PULSE_CNT_WIDTH 19

`endif

// [rtl/osc_tick_divider.v]
`timescale 1ns/1ns
`default_nettype none
`include "wdt_timer_defs.vh"

module osc_tick_divider
(
  input wire sys_clk,
  input wire rst,
  input wire osc_32k,
  output wire tick_4096hz,
  output wire tick_64hz,
  output wire tick_1hz,
  output reg tick_60s
);

  reg osc_prev;
  reg [`DIV_WIDTH-1:0] div;
  reg [5:0] sec_cnt;
  wire osc_edge;
  wire [2:0] taps;

  assign osc_edge = osc_32k & ~osc_prev;

  // ***************************************************************
  // divider chain on the oscillator edge
  // ***************************************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_prev <= 1'b0;
      div <= {`DIV_WIDTH{1'b0}};
    end
    else
    begin
      osc_prev <= osc_32k;
      if (osc_edge)
        div <= div + {{(`DIV_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // one-cycle enables where the low bits all roll over
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_tap
      localparam integer W = (i == 0) ? `TAP_4096HZ :
                             (i == 1) ? `TAP_64HZ : `TAP_1HZ;
      assign taps[i] = osc_edge & (&div[W-1:0]);
    end
  endgenerate

  assign tick_4096hz = taps[0];
  assign tick_64hz = taps[1];
  assign tick_1hz = taps[2];

  // ***************************************************************
  // minute tick from sixty seconds
  // ***************************************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sec_cnt <= 6'h00;
      tick_60s <= 1'b0;
    end
    else
    begin
      tick_60s <= 1'b0;
      if (tick_1hz)
      begin
        if (sec_cnt == `SECONDS_PER_MINUTE - 6'h01)
        begin
          sec_cnt <= 6'h00;
          tick_60s <= 1'b1;
        end
        else
          sec_cnt <= sec_cnt + 6'h01;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/reset_pulse_gen.v]
`timescale 1ns/1ns
`default_nettype none
`include "wdt_timer_defs.vh"

module reset_pulse_gen
#(
  parameter [`PULSE_CNT_WIDTH-1:0] FAST_CYC = `RESET_PULSE_FAST_CYC,
  parameter [`PULSE_CNT_WIDTH-1:0] SLOW_CYC = `RESET_PULSE_SLOW_CYC
)
(
  input wire sys_clk,
  input wire rst,
  input wire start,
  input wire stop,
  input wire fast,
  output reg active
);

  reg [`PULSE_CNT_WIDTH-1:0] remain;

  // stop wins: a reload releases the reset at once
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      remain <= {`PULSE_CNT_WIDTH{1'b0}};
    end
    else if (stop)
    begin
      active <= 1'b0;
      remain <= {`PULSE_CNT_WIDTH{1'b0}};
    end
    else if (start)
    begin
      active <= 1'b1;
      remain <= fast ? FAST_CYC : SLOW_CYC;
    end
    else if (active)
    begin
      if (remain <= {{(`PULSE_CNT_WIDTH-1){1'b0}}, 1'b1})
        active <= 1'b0;
      remain <= remain - {{(`PULSE_CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// [rtl/watchdog_countdown_timer.v]
// Operation
// - mode field: off, countdown, watchdog irq/reset
// - tick select: 4096 Hz, 64 Hz, 1 Hz, minute
// - eight-bit count n sets period n ticks
// - watchdog counts down, flag at one
// - expired flag drives irq or reset
// - expired watchdog never reloads by itself
// - nonzero load clears, releases, restarts watchdog
// - zero load clears, releases, halts watchdog
// - watchdog flag cleared by load or read
// - reset pulse width follows tick select
// - countdown at one flags and reloads
// - zero count halts the countdown
// - count read returns live counter
// - new count takes effect at once
// - first countdown period may be one tick off
// - countdown irq needs its enable
// - pulse select: level or pulse irq
// - second/minute ticks set minsec flag
// - status write ANDs into flags except watchdog
// - flag positions in status register
`timescale 1ns/1ns
`default_nettype none
`include "wdt_timer_defs.vh"

module watchdog_countdown_timer
#(
  parameter [`PULSE_CNT_WIDTH-1:0] RESET_FAST_CYC = `RESET_PULSE_FAST_CYC,
  parameter [`PULSE_CNT_WIDTH-1:0] RESET_SLOW_CYC = `RESET_PULSE_SLOW_CYC
)
(
  input wire sys_clk,
  input wire rst,
  input wire osc_32k,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire countdown_irq_en,
  input wire one_hz_tick_en,
  input wire sixty_s_tick_en,
  input wire alarm_match_evt,
  input wire stamp_low_evt,
  output reg irq_n,
  output reg sys_reset_n
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  reg [7:0] timer_control;
  reg [7:0] reload_n;
  reg [7:0] count;
  reg wdog_run;
  reg minsec_flag;
  reg wdog_expired_flag;
  reg stamp_low_flag;
  reg alarm_match_flag;
  reg countdown_expired_flag;
  reg [2:0] status_low;
  reg irq_pulse_hold;
  reg next_irq;
  reg sel_tick;
  reg next_skip;
  reg cd_skip;
  reg [5:0] sub_sec;
  reg [5:0] sec_phase;
  wire tick_4096hz;
  wire tick_64hz;
  wire tick_1hz;
  wire tick_60s;
  wire [1:0] timer_mode_sel;
  wire [1:0] tick_source_sel;
  wire irq_pulse_sel;
  wire wdog_mode;
  wire cd_mode;
  wire wr_control;
  wire wr_count;
  wire wr_status;
  wire rd_status;
  wire wdog_expire;
  wire cd_active;
  wire cd_expire;
  wire minsec_evt;
  wire reset_active;
  wire [7:0] flag_status;

  // ***************************************************************
  // tick sources
  // ***************************************************************
  osc_tick_divider u_div
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .osc_32k(osc_32k),
    .tick_4096hz(tick_4096hz),
    .tick_64hz(tick_64hz),
    .tick_1hz(tick_1hz),
    .tick_60s(tick_60s)
  );

  assign timer_mode_sel = timer_control[`MODE_HI:`MODE_LO];
  assign tick_source_sel = timer_control[`TICK_SEL_HI:`TICK_SEL_LO];
  assign irq_pulse_sel = timer_control[`PULSE_SEL_BIT];

  // countdown is unavailable in either watchdog mode
  assign wdog_mode = timer_mode_sel[1];
  assign cd_mode = (timer_mode_sel == `MODE_COUNTDOWN);

  always @*
  begin
    sel_tick = 1'b0;
    case (tick_source_sel)
      `TICK_4096HZ: sel_tick = tick_4096hz;
      `TICK_64HZ: sel_tick = tick_64hz;
      `TICK_1HZ: sel_tick = tick_1hz;
      default: sel_tick = tick_60s;
    endcase
  end

  // second/minute events from the free-running chain
  assign minsec_evt = (tick_1hz & one_hz_tick_en) |
                      (tick_60s & sixty_s_tick_en);

  // ***************************************************************
  // register access decode
  // ***************************************************************
  assign wr_control = reg_wr & (reg_addr == `ADDR_TIMER_CONTROL);
  assign wr_count = reg_wr & (reg_addr == `ADDR_TIMER_COUNT_VALUE);
  assign wr_status = reg_wr & (reg_addr == `ADDR_FLAG_STATUS);
  assign rd_status = reg_rd & (reg_addr == `ADDR_FLAG_STATUS);

  // ***************************************************************
  // expiry conditions
  // ***************************************************************
  // watchdog fires on the tick that finds the count at one
  assign wdog_expire = wdog_mode & wdog_run & sel_tick &
                       (count == 8'h01);
  // stored zero halts the countdown
  assign cd_active = cd_mode & (reload_n != 8'h00);
  assign cd_expire = cd_active & sel_tick & ~cd_skip &
                     (count == 8'h01);

  // ***************************************************************
  // control register
  // ***************************************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      timer_control <= `TIMER_CONTROL_RESET;
    else if (wr_control)
      timer_control <= reg_wdata & `TIMER_CONTROL_WMASK;
  end

  // ***************************************************************
  // down-counter
  // ***************************************************************
  // the tick prescaler runs free; a skipped first tick keeps the
  // first countdown period after a load near n ticks
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reload_n <= `COUNT_RESET;
      count <= `COUNT_RESET;
    end
    else if (wr_count)
    begin
      // load takes effect at once, also mid-period
      reload_n <= reg_wdata;
      count <= reg_wdata;
    end
    else if (wdog_mode & wdog_run & sel_tick & (count > 8'h01))
      count <= count - 8'h01;
    else if (cd_active & sel_tick & ~cd_skip)
    begin
      if (count <= 8'h01)
        count <= reload_n;
      else
        count <= count - 8'h01;
    end
  end

  // 64 Hz ticks into the second and seconds into the minute
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sub_sec <= 6'h00;
      sec_phase <= 6'h00;
    end
    else if (tick_1hz)
    begin
      sub_sec <= 6'h00;
      if (sec_phase == `SECONDS_PER_MINUTE - 6'h01)
        sec_phase <= 6'h00;
      else
        sec_phase <= sec_phase + 6'h01;
    end
    else if (tick_64hz)
      sub_sec <= sub_sec + 6'h01;
  end

  // a load late in a slow tick interval skips that tick
  always @*
  begin
    next_skip = 1'b1;
    if (tick_source_sel == `TICK_1HZ)
      next_skip = (sub_sec >= `HALF_SECOND_TICKS);
    else if (tick_source_sel == `TICK_60S)
      next_skip = (sec_phase >= `HALF_MINUTE);
  end

  // countdown may pass over the first tick after a load
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cd_skip <= 1'b0;
    else if (wr_count)
      cd_skip <= next_skip;
    else if (cd_active & sel_tick)
      cd_skip <= 1'b0;
  end

  // watchdog run state: no reload after expiry
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wdog_run <= 1'b0;
    else if (wr_count)
      wdog_run <= (reg_wdata != 8'h00);
    else if (wdog_expire)
      wdog_run <= 1'b0;
  end

  // ***************************************************************
  // flags
  // ***************************************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wdog_expired_flag <= 1'b0;
    else if (wdog_expire)
      wdog_expired_flag <= 1'b1;
    else if (wr_count | rd_status)
      wdog_expired_flag <= 1'b0;
  end

  // a written zero clears, a one keeps; events win over clears
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      minsec_flag <= 1'b0;
      stamp_low_flag <= 1'b0;
      alarm_match_flag <= 1'b0;
      countdown_expired_flag <= 1'b0;
      status_low <= 3'h0;
    end
    else
    begin
      minsec_flag <= minsec_evt |
        (minsec_flag & ~(wr_status & ~reg_wdata[`MINSEC_BIT]));
      stamp_low_flag <= stamp_low_evt |
        (stamp_low_flag & ~(wr_status & ~reg_wdata[`STAMP_LOW_BIT]));
      alarm_match_flag <= alarm_match_evt |
        (alarm_match_flag & ~(wr_status & ~reg_wdata[`ALARM_BIT]));
      countdown_expired_flag <= cd_expire |
        (countdown_expired_flag &
         ~(wr_status & ~reg_wdata[`COUNTDOWN_BIT]));
      // watchdog bit position ignores writes
      if (wr_status)
        status_low <= reg_wdata[2:0];
    end
  end

  // flag placement
  assign flag_status = {minsec_flag, wdog_expired_flag, stamp_low_flag,
                        alarm_match_flag, countdown_expired_flag,
                        status_low};

  // ***************************************************************
  // read data
  // ***************************************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `ADDR_TIMER_CONTROL)
        reg_rdata <= timer_control;
      else if (reg_addr == `ADDR_TIMER_COUNT_VALUE)
        reg_rdata <= count;
      else if (reg_addr == `ADDR_FLAG_STATUS)
        reg_rdata <= flag_status;
      else
        reg_rdata <= 8'h00;
    end
  end

  // ***************************************************************
  // interrupt output
  // ***************************************************************
  // pulse starts on a minsec or enabled countdown event and ends at the next 64 Hz tick
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_pulse_hold <= 1'b0;
    else if (irq_pulse_sel &
             (minsec_evt | (cd_expire & countdown_irq_en)))
      irq_pulse_hold <= 1'b1;
    else if (tick_64hz | ~irq_pulse_sel)
      irq_pulse_hold <= 1'b0;
  end

  always @*
  begin
    next_irq = 1'b0;
    if (timer_mode_sel == `MODE_WDOG_IRQ)
      next_irq = wdog_expired_flag;
    if (irq_pulse_sel)
      next_irq = next_irq | irq_pulse_hold;
    else
      next_irq = next_irq | minsec_flag |
        (cd_mode & countdown_irq_en & countdown_expired_flag);
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_n <= 1'b1;
    else
      irq_n <= ~next_irq;
  end

  // ***************************************************************
  // reset output
  // ***************************************************************
  reset_pulse_gen
  #(
    .FAST_CYC(RESET_FAST_CYC),
    .SLOW_CYC(RESET_SLOW_CYC)
  )
  u_rst
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(wdog_expire & (timer_mode_sel == `MODE_WDOG_RST)),
    .stop(wr_count),
    .fast(tick_source_sel == `TICK_4096HZ),
    .active(reset_active)
  );

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sys_reset_n <= 1'b1;
    else
      sys_reset_n <= ~reset_active;
  end

endmodule
`default_nettype wire

// [verification/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model
(
  input wire sys_clk,
  input wire sys_reset_n,
  output logic osc_32k,
  output logic [15:0] rst_width
);
  logic [15:0] run;
  initial
  begin
    osc_32k = 1'b0;
    rst_width = 16'h0000;
    run = 16'h0000;
  end
  // oscillator runs fast to keep the run short
  always @(posedge sys_clk)
  begin
    osc_32k <= #1 ~osc_32k;
    if (!sys_reset_n)
      run <= run + 16'h0001;
    else if (run != 16'h0000)
    begin
      rst_width <= run;
      run <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [verification/wdt_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module wdt_checker
#(
  parameter [18:0] RESET_FAST_CYC = 19'd4880,
  parameter [18:0] RESET_SLOW_CYC = 19'd312500
)
(
  input wire sys_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire countdown_irq_en,
  input wire one_hz_tick_en,
  input wire sixty_s_tick_en,
  input wire irq_n,
  input wire sys_reset_n
);
  logic [1:0] mode;
  logic [18:0] low_cnt;
  wire cnt_wr = reg_wr && reg_addr == 8'h11;
  wire cnt_rd = reg_rd && reg_addr == 8'h11;
  wire quiet = !countdown_irq_en && !one_hz_tick_en && !sixty_s_tick_en;
  // shadow of the mode field
  always @(posedge sys_clk or posedge rst)
    if (rst)
      mode <= 2'h0;
    else if (reg_wr && reg_addr == 8'h10)
      mode <= reg_wdata[7:6];
  // cycles the reset output has been low so far
  always @(posedge sys_clk or posedge rst)
    if (rst)
      low_cnt <= 19'h00000;
    else if (sys_reset_n)
      low_cnt <= 19'h00000;
    else
      low_cnt <= low_cnt + 19'h00001;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_tc_rw;
    reg_wr && reg_addr == 8'h10 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h10
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'he3);
  endproperty
  a_tc_rw: assert property (p_tc_rw)
    else $error("control readback wrong");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_freeze;
    cnt_rd && !reg_wr && mode == 2'h0 ##1 !reg_wr ##1 cnt_rd && !reg_wr
      |=> $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("count moved while off");
  property p_rst_rel;
    cnt_wr && reg_wdata > 8'h01 |-> ##3 sys_reset_n;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("reset out not released by load");
  property p_irq_rel;
    cnt_wr && reg_wdata == 8'h00 && mode == 2'h2 && quiet |-> ##3 irq_n;
  endproperty
  a_irq_rel: assert property (p_irq_rel)
    else $error("irq not released by zero load");
  property p_rst_wid;
    $fell(sys_reset_n) ##1 (!cnt_wr) [*6] |-> !sys_reset_n;
  endproperty
  a_rst_wid: assert property (p_rst_wid)
    else $error("reset pulse too short");
  property p_rst_max;
    !sys_reset_n |-> low_cnt < RESET_SLOW_CYC + 19'h00002;
  endproperty
  a_rst_max: assert property (p_rst_max)
    else $error("reset pulse too long");
  property p_rst_mode;
    $fell(sys_reset_n) |-> mode == 2'h3;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("reset pulse outside reset mode");
endmodule
bind watchdog_countdown_timer wdt_checker #(
  .RESET_FAST_CYC(RESET_FAST_CYC),
  .RESET_SLOW_CYC(RESET_SLOW_CYC)
) u_wdt_checker (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .countdown_irq_en(countdown_irq_en),
  .one_hz_tick_en(one_hz_tick_en),
  .sixty_s_tick_en(sixty_s_tick_en),
  .irq_n(irq_n),
  .sys_reset_n(sys_reset_n)
);
`default_nettype wire

// [verification/watchdog_countdown_timer_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module watchdog_countdown_timer_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic cd_en = 1'b0;
  logic one_hz = 1'b0;
  logic sixty_s = 1'b0;
  logic alarm_evt = 1'b0;
  logic stamp_evt = 1'b0;
  wire osc_32k;
  wire [7:0] reg_rdata;
  wire irq_n;
  wire sys_reset_n;
  wire [15:0] rst_width;
  integer fail_count = 0;
  integer checks = 0;
  integer cyc = 0;
  integer t0;
  logic [7:0] d;
  logic [7:0] d2;
  watchdog_countdown_timer #(
    .RESET_FAST_CYC(19'd8),
    .RESET_SLOW_CYC(19'd20)
  ) u_watchdog_countdown_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .osc_32k(osc_32k),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .countdown_irq_en(cd_en),
    .one_hz_tick_en(one_hz),
    .sixty_s_tick_en(sixty_s),
    .alarm_match_evt(alarm_evt),
    .stamp_low_evt(stamp_evt),
    .irq_n(irq_n),
    .sys_reset_n(sys_reset_n)
  );
  host_model u_host_model (
    .sys_clk(sys_clk),
    .sys_reset_n(sys_reset_n),
    .osc_32k(osc_32k),
    .rst_width(rst_width)
  );
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ***************************************************************
  // access tasks
  // ***************************************************************
  task chk(input [63:0] nm, input [7:0] s, input [7:0] e);
    begin
      checks = checks + 1;
      if (s !== e)
      begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      v = reg_rdata;
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  // wait for irq_n (sel 0) or sys_reset_n (sel 1) to reach lvl
  task wt(input logic sel, input logic lvl, input integer lim);
    integer i;
    logic p;
    begin
      i = 0;
      p = sel ? sys_reset_n : irq_n;
      while (p !== lvl && i < lim)
      begin
        idle(1);
        p = sel ? sys_reset_n : irq_n;
        i = i + 1;
      end
      chk("pin", {7'h00, p}, {7'h00, lvl});
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ***************************************************************
  // tests
  // ***************************************************************
  initial
  begin
    idle(12);
    rst = 1'b0;
    rd(8'h10, d);
    chk("tc", d, 8'h03);
    rd(8'h11, d);
    chk("cnt", d, 8'h00);
    rd(8'h01, d);
    chk("flags", d, 8'h00);
    rd(8'h20, d);
    chk("unmap", d, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, d);
    chk("tc", d, 8'he3);
    wr(8'h10, 8'hc0);
    wr(8'h11, 8'h03);
    wt(1, 0, 200);
    wt(1, 1, 100);
    idle(2);
    chk("rstw", {7'h00, rst_width >= 7 && rst_width <= 9}, 8'h01);
    idle(100);
    wt(1, 1, 0);
    rd(8'h11, d);
    rd(8'h11, d2);
    chk("cnt", d, 8'h01);
    chk("cnt", d2, 8'h01);
    wr(8'h01, 8'h00);
    rd(8'h01, d);
    chk("flags", d, 8'h40);
    rd(8'h01, d);
    chk("flags", d, 8'h00);
    wr(8'h10, 8'hc1);
    wr(8'h11, 8'h01);
    wt(1, 0, 2200);
    wt(1, 1, 100);
    idle(2);
    chk("rstw", {7'h00, rst_width >= 19 && rst_width <= 21}, 8'h01);
    rd(8'h01, d);
    chk("flags", d, 8'h40);
    wr(8'h10, 8'h80);
    wr(8'h11, 8'h02);
    wt(0, 0, 100);
    wt(1, 1, 0);
    wr(8'h11, 8'h03);
    wt(0, 1, 3);
    wt(0, 0, 100);
    wr(8'h11, 8'h00);
    wt(0, 1, 3);
    idle(100);
    wt(0, 1, 0);
    rd(8'h01, d);
    chk("flags", d, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h05);
    idle(60);
    rd(8'h11, d);
    rd(8'h11, d2);
    chk("cnt", d, 8'h05);
    chk("cnt", d2, 8'h05);
    cd_en = 1'b1;
    wr(8'h01, 8'h00);
    wr(8'h10, 8'h40);
    wr(8'h11, 8'h02);
    wt(0, 0, 100);
    t0 = cyc;
    rd(8'h01, d);
    chk("flags", d, 8'h08);
    wr(8'h01, 8'hb0);
    wt(0, 1, 5);
    wt(0, 0, 40);
    chk("per", 8'(cyc - t0), 8'd32);
    cd_en = 1'b0;
    wr(8'h01, 8'hb0);
    idle(40);
    wt(0, 1, 0);
    rd(8'h01, d);
    chk("flags", d, 8'h08);
    wr(8'h11, 8'h00);
    wr(8'h01, 8'h00);
    idle(60);
    rd(8'h01, d);
    chk("flags", d, 8'h00);
    cd_en = 1'b1;
    wr(8'h10, 8'h60);
    wr(8'h11, 8'hff);
    wt(0, 0, 4300);
    wt(0, 1, 1100);
    rd(8'h01, d);
    chk("flags", d, 8'h08);
    wr(8'h10, 8'h00);
    wr(8'h01, 8'h00);
    alarm_evt = 1'b1;
    stamp_evt = 1'b1;
    idle(1);
    alarm_evt = 1'b0;
    stamp_evt = 1'b0;
    rd(8'h01, d);
    chk("flags", d, 8'h30);
    wr(8'h01, 8'h90);
    rd(8'h01, d);
    chk("flags", d, 8'h10);
    // 1 Hz watchdog and second event land on one tick
    wr(8'h10, 8'h82);
    wr(8'h11, 8'h01);
    one_hz = 1'b1;
    wt(0, 0, 65000);
    rd(8'h01, d);
    chk("flags", d, 8'hd0);
    wr(8'h01, 8'h10);
    one_hz = 1'b0;
    wt(0, 1, 3);
    rd(8'h01, d);
    chk("flags", d, 8'h10);
    end_of_test;
  end
  initial
  begin
    #4000000;
    fail_count = fail_count + 1;
    end_of_test;
  end
endmodule
`default_nettype wire
